// ==== rtl/epi_cfg.svh ====
// register indexes, field positions, reset values and write masks of the pin interrupt unit
// assumes: included by bare name; indexes are word indexes, byte address is four times index
`ifndef EPI_CFG_SVH
`define EPI_CFG_SVH

`define EPI_IDX_GRP_FLAGS   7'h1b
`define EPI_IDX_EXT_FLAGS   7'h1c
`define EPI_IDX_EXT_MASK    7'h1d
`define EPI_IDX_GRP_EN      7'h68
`define EPI_IDX_SENSE       7'h69
`define EPI_IDX_CHG_MASK0   7'h6b
`define EPI_IDX_CHG_MASK1   7'h6c
`define EPI_IDX_CHG_MASK2   7'h6d

`define EPI_RST_BYTE        8'h00
`define EPI_SYNC_RST        26'h3000000
`define EPI_SENSE_A_LSB     0
`define EPI_SENSE_B_LSB     2
`define EPI_PIN_A_SYNC      24
`define EPI_PIN_B_SYNC      25
`define EPI_CHG_VALID       24'hff7fff

`endif

// ==== rtl/epi_pkg.sv ====
// types of the pin interrupt unit: sense codes, bus states, request bundle, state record
// assumes: epi_cfg.svh supplies the numeric constants
package epi_pkg;

    typedef enum logic [1:0] {
        SENSE_LOW  = 2'b00,
        SENSE_ANY  = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } epi_sense_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANS  = 2'b10
    } epi_bus_e;

    typedef struct packed {
        logic group_two;
        logic group_one;
        logic group_zero;
        logic pin_b;
        logic pin_a;
    } epi_req_s;

    typedef struct packed {
        epi_bus_e    bus;
        logic [7:0]  rdata;
        logic [3:0]  sense;
        logic [1:0]  ext_mask;
        logic [1:0]  ext_flag;
        logic [2:0]  grp_en;
        logic [2:0]  grp_flag;
        logic [23:0] chg_mask;
        logic [25:0] s1;
        logic [25:0] s2;
        logic [25:0] s3;
        logic [25:0] stable;
    } epi_state_s;

endpackage : epi_pkg

// ==== rtl/epi_top.sv ====
// pin interrupt unit: two sense-selectable pins, 23 pin-change inputs in three groups
// assumes: one 40 MHz clock, Avalon-MM slave with waitrequest, core gives its global enable
//
// What this block does
// [R1] pins raise interrupts from their level, whatever the port direction.
// [R2] group two watches inputs 23..16, group one 14..8, group zero 7..0.
// [R3] pin-change activity produces a wake signal with no clock needed.
// [R4] enabled level-sensed pin requests for as long as it stays low.
// [R5] rising and falling edges are seen only while the clock runs.
// [R6] low level on a dedicated pin produces wake with no clock needed.
// [R7] driver must hold a wake level until start-up completes.
// [R8] sense field: pin b bits 3..2, pin a 1..0; 00 low,01 any,10 fall,11 rise.
// [R9] pins are sampled first; pulses over two clock periods always register.
// [R10] driver must hold a level-sense low until the running instruction ends.
// [R11] mask bit 1 enables pin b, bit 0 pin a, gated by global enable.
// [R12] unused bits of mask, flag and group control registers read zero.
// [R13] an edge or change sets the pin flag; masked request goes to core.
// [R14] pin flag clears on handler acknowledge or written one.
// [R15] pin flag stays zero while its pin is level sensed.
// [R16] each pin and each group has its own request line.
// [R17] group enable bits 2,1,0 with global enable gate group requests.
// [R18] each group member has its own mask bit.
// [R19] group flag sets on a member change; clears on acknowledge or written one.
// [R20] a member counts only when its mask bit and group enable are set; the code sets the group flag on the mask bit alone.
// [R21] dedicated pins are synchronised before edge comparison.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`include "epi_cfg.svh"

module epi_top
    import epi_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [8:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        ext_irq_pin_a_i,
    input  wire logic        ext_irq_pin_b_i,
    input  wire logic [23:0] change_detect_inputs_i,
    input  wire logic        global_irq_enable_i,
    input  wire epi_req_s    irq_ack_i,
    output epi_req_s         irq_req_o,
    output logic             wake_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic sense_hit(input logic [1:0] code,
                                       input logic       rise,
                                       input logic       fall);
        logic hit;
        hit = 1'b0;
        case (epi_sense_e'(code))
            SENSE_ANY:  hit = rise | fall;
            SENSE_FALL: hit = fall;
            SENSE_RISE: hit = rise;
            default:    hit = 1'b0;
        endcase
        return hit; // [R8]
    endfunction : sense_hit

    function automatic logic [7:0] reg_read(input logic [6:0]  idx,
                                            input epi_state_s  s);
        logic [7:0] v;
        v = `EPI_RST_BYTE;
        if (idx == `EPI_IDX_EXT_MASK)
            v = {6'h00, s.ext_mask}; // [R12]
        else if (idx == `EPI_IDX_EXT_FLAGS)
            v = {6'h00, s.ext_flag};
        else if (idx == `EPI_IDX_SENSE)
            v = {4'h0, s.sense};
        else if (idx == `EPI_IDX_GRP_EN)
            v = {5'h00, s.grp_en}; // [R12]
        else if (idx == `EPI_IDX_GRP_FLAGS)
            v = {5'h00, s.grp_flag}; // [R12]
        else if (idx == `EPI_IDX_CHG_MASK0)
            v = s.chg_mask[7:0];
        else if (idx == `EPI_IDX_CHG_MASK1)
            v = s.chg_mask[15:8];
        else if (idx == `EPI_IDX_CHG_MASK2)
            v = s.chg_mask[23:16];
        else
            v = `EPI_RST_BYTE;
        return v;
    endfunction : reg_read

    ////////////////////////////////////////////////////////////////////////////////
    // state

    epi_state_s  q;
    epi_state_s  next_q;
    logic [25:0] raw_pins;
    logic [25:0] agree;
    logic [25:0] change;
    logic [25:0] rise;
    logic [25:0] fall;
    logic [1:0]  ext_hit;
    logic [1:0]  ext_level;
    logic [1:0]  ext_low;
    logic [2:0]  grp_hit;
    logic [2:0]  grp_wake;

    // pins are taken as seen, so driving them as outputs still triggers
    assign raw_pins = {ext_irq_pin_b_i, ext_irq_pin_a_i, change_detect_inputs_i}; // [R1]

    // a change counts once stages two and three agree; stage one feeds stage two only
    assign agree  = ~(q.s2 ^ q.s3); // [R9] [R21]
    assign change = agree & (q.s3 ^ q.stable); // [R5]
    assign rise   = change & q.s3;
    assign fall   = change & ~q.s3;

    ////////////////////////////////////////////////////////////////////////////////
    // dedicated pins

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++)
        begin : g_pin
            localparam int SL = (gp == 0) ? `EPI_SENSE_A_LSB : `EPI_SENSE_B_LSB;
            localparam int PI = (gp == 0) ? `EPI_PIN_A_SYNC : `EPI_PIN_B_SYNC;
            assign ext_level[gp] = (epi_sense_e'(q.sense[SL +: 2]) == SENSE_LOW);
            assign ext_hit[gp]   = sense_hit(q.sense[SL +: 2], rise[PI], fall[PI]); // [R13]
            assign ext_low[gp]   = ext_level[gp] & q.ext_mask[gp] & ~raw_pins[PI]; // [R6]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // pin-change groups

    genvar gg;
    generate
        for (gg = 0; gg < 3; gg++)
        begin : g_grp
            logic [7:0] live;
            // bit 15 has no pin; its mask bit is held at zero
            assign live         = q.chg_mask[gg*8 +: 8]; // [R18]
            assign grp_hit[gg]  = |(change[gg*8 +: 8] & live); // [R2]
            // wake looks at the raw pins against the settled value, no clock edge needed
            assign grp_wake[gg] = q.grp_en[gg]
                                  & |((raw_pins[gg*8 +: 8] ^ q.stable[gg*8 +: 8]) & live); // [R3] [R20]
        end
    endgenerate

    assign wake_o = |ext_low | |grp_wake; // [R3] [R6]

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic [6:0] idx;
        logic [7:0] wd;
        logic       wr;
        logic [1:0] ext_clr;
        logic [2:0] grp_clr;

        idx     = avs_address_i[8:2];
        wd      = avs_writedata_i[7:0];
        wr      = 1'b0;
        ext_clr = {irq_ack_i.pin_b, irq_ack_i.pin_a}; // [R14]
        grp_clr = {irq_ack_i.group_two, irq_ack_i.group_one, irq_ack_i.group_zero}; // [R19]
        next_q  = q;

        next_q.s1     = raw_pins;
        next_q.s2     = q.s1;
        next_q.s3     = q.s2;
        next_q.stable = (q.stable & ~agree) | (q.s3 & agree); // [R9]

        // one wait state: the answer cycle is the only one with waitrequest low
        case (q.bus)
            BUS_IDLE:
            begin
                if (avs_read_i || avs_write_i)
                begin
                    next_q.bus   = BUS_ANS;
                    next_q.rdata = reg_read(idx, q);
                end
            end
            BUS_ANS:
            begin
                next_q.bus = BUS_IDLE;
                wr         = avs_write_i & avs_byteenable_i[0];
            end
            default:
            begin
                next_q.bus = BUS_IDLE;
            end
        endcase

        if (wr)
        begin
            if (idx == `EPI_IDX_EXT_MASK)
                next_q.ext_mask = wd[1:0]; // [R11]
            else if (idx == `EPI_IDX_EXT_FLAGS)
                ext_clr = ext_clr | wd[1:0]; // [R14]
            else if (idx == `EPI_IDX_SENSE)
                next_q.sense = wd[3:0]; // [R8]
            else if (idx == `EPI_IDX_GRP_EN)
                next_q.grp_en = wd[2:0]; // [R17]
            else if (idx == `EPI_IDX_GRP_FLAGS)
                grp_clr = grp_clr | wd[2:0]; // [R19]
            else if (idx == `EPI_IDX_CHG_MASK0)
                next_q.chg_mask[7:0] = wd;
            else if (idx == `EPI_IDX_CHG_MASK1)
                next_q.chg_mask[15:8] = {1'b0, wd[6:0]}; // [R12]
            else if (idx == `EPI_IDX_CHG_MASK2)
                next_q.chg_mask[23:16] = wd;
        end

        // a new event in the clearing cycle wins over the clear
        next_q.ext_flag = ~ext_level & (ext_hit | (q.ext_flag & ~ext_clr)); // [R13] [R15]
        next_q.grp_flag = grp_hit | (q.grp_flag & ~grp_clr); // [R19]
        next_q.chg_mask = next_q.chg_mask & `EPI_CHG_VALID;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            q     <= '0;
            q.bus <= BUS_IDLE;
            // dedicated pins idle high; zeros here would fake a rising edge after reset
            q.s1     <= `EPI_SYNC_RST;
            q.s2     <= `EPI_SYNC_RST;
            q.s3     <= `EPI_SYNC_RST;
            q.stable <= `EPI_SYNC_RST;
        end
        else
        begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign avs_readdata_o    = {24'h000000, q.rdata};
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & (q.bus != BUS_ANS);

    // level mode requests straight from the settled low level, no flag involved
    assign irq_req_o.pin_a      = global_irq_enable_i & q.ext_mask[0]
                                  & (ext_level[0] ? ~q.stable[`EPI_PIN_A_SYNC]
                                                  : q.ext_flag[0]); // [R4] [R11] [R16]
    assign irq_req_o.pin_b      = global_irq_enable_i & q.ext_mask[1]
                                  & (ext_level[1] ? ~q.stable[`EPI_PIN_B_SYNC]
                                                  : q.ext_flag[1]); // [R4] [R11] [R16]
    assign irq_req_o.group_zero = global_irq_enable_i & q.grp_en[0] & q.grp_flag[0]; // [R17]
    assign irq_req_o.group_one  = global_irq_enable_i & q.grp_en[1] & q.grp_flag[1]; // [R17]
    assign irq_req_o.group_two  = global_irq_enable_i & q.grp_en[2] & q.grp_flag[2]; // [R16]

endmodule : epi_top

// ==== verif/epi_pin_model.sv ====
// external circuitry driving the dedicated pins and the pin-change inputs
// assumes: bench sets wanted levels; bit 25 pin b, bit 24 pin a, 23:0 inputs
`timescale 1ns/1ps
module epi_pin_model (
    input  wire logic        clk_i,
    input  wire logic [25:0] lvl_i,
    output logic             pin_a_o,
    output logic             pin_b_o,
    output logic [23:0]      chg_o
);
    // levels change only on clock edges, so every pulse spans a whole period
    logic [25:0] held = 26'h3000000;
    always @(posedge clk_i) held <= lvl_i;
    assign pin_b_o = held[25];
    assign pin_a_o = held[24];
    assign chg_o   = held[23:0];
endmodule : epi_pin_model

// ==== verif/epi_top_assertions.sv ====
// port-level checks of the pin interrupt unit
// assumes: bound into epi_top, one clock, synchronous active-low reset
`timescale 1ns/1ps
`include "epi_cfg.svh"
module epi_top_assertions
    import epi_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic [8:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        ext_irq_pin_a_i,
    input wire logic        ext_irq_pin_b_i,
    input wire logic [23:0] change_detect_inputs_i,
    input wire logic        global_irq_enable_i,
    input wire epi_req_s    irq_ack_i,
    input wire epi_req_s    irq_req_o,
    input wire logic        wake_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       ans;
    logic [6:0] idx;
    assign ans = avs_read_i && !avs_waitrequest_o;
    assign idx = avs_address_i[8:2];
    ////////////////////////////////////////////////////////////////////////
    chk_gie_gates: assert property (!global_irq_enable_i |-> irq_req_o == '0)
        else $error("request while global enable low");
    chk_mask_rsvd: assert property (ans && idx == `EPI_IDX_EXT_MASK
        |-> avs_readdata_o[31:2] == '0)
        else $error("mask reserved bits set");
    chk_eflag_rsvd: assert property (ans && idx == `EPI_IDX_EXT_FLAGS
        |-> avs_readdata_o[31:2] == '0)
        else $error("pin flag reserved bits set");
    chk_gflag_rsvd: assert property (ans && idx == `EPI_IDX_GRP_FLAGS
        |-> avs_readdata_o[31:3] == '0)
        else $error("group flag reserved bits set");
    chk_gen_rsvd: assert property (ans && idx == `EPI_IDX_GRP_EN
        |-> avs_readdata_o[31:3] == '0)
        else $error("group enable reserved bits set");
    // a quiet, high set of pins leaves nothing to wake for
    chk_quiet_wake: assert property ((ext_irq_pin_a_i && ext_irq_pin_b_i
        && $stable(change_detect_inputs_i))[*5] |-> !wake_o)
        else $error("wake with quiet pins");
    chk_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o)
        else $error("more than one wait state");
    chk_ack_clears: assert property (($stable(change_detect_inputs_i)[*5] ##0
        irq_ack_i.group_zero) |=> !irq_req_o.group_zero)
        else $error("group request held after acknowledge");
endmodule : epi_top_assertions

// ==== verif/epi_top_tb_top.sv ====
// self-checking bench of the pin interrupt unit with a pin driver model
// assumes: epi_top one-wait-state Avalon slave; byteenable tied to all lanes
`timescale 1ns/1ps
module epi_top_tb_top
    import epi_pkg::*;
;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic global_irq_enable_i = 1'b0, avs_waitrequest_o, wake_o;
    logic [8:0] avs_address_i = '0;
    logic [31:0] avs_writedata_i = '0, avs_readdata_o, seed = 32'h0000c820;
    logic [25:0] lvl = 26'h3000000;
    wire ext_irq_pin_a_i, ext_irq_pin_b_i;
    wire [23:0] change_detect_inputs_i;
    epi_req_s irq_ack_i = '0, irq_req_o;
    int n_mismatch = 0, check_count = 0, cyc = 0;
    logic [6:0] tab_i [9] = '{7'h1d, 7'h68, 7'h1b, 7'h1c, 7'h69, 7'h6b, 7'h6c, 7'h6d, 7'h70};
    logic [7:0] tab_e [9] = '{8'h03, 8'h07, 8'h00, 8'h00, 8'h0f, 8'hff, 8'h7f, 8'hff, 8'h00};
    epi_top u_dut (.sys_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o,
        .ext_irq_pin_a_i, .ext_irq_pin_b_i, .change_detect_inputs_i, .global_irq_enable_i,
        .irq_ack_i, .irq_req_o, .wake_o);
    epi_pin_model u_pins (.clk_i(sys_clk_i), .lvl_i(lvl), .pin_a_o(ext_irq_pin_a_i),
        .pin_b_o(ext_irq_pin_b_i), .chg_o(change_detect_inputs_i));
    always #12.5 sys_clk_i = ~sys_clk_i;
    ////////////////////////////////////////////////////////////////////////
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // edge modes keep the flag, so only level sense drops on release
    function logic exp_pin(input int c, input logic hi);
        return hi ? (c != 0) : (c != 3);
    endfunction : exp_pin
    task close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task cyc_n(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : cyc_n
    task bus(input logic w, input logic [6:0] i, input logic [7:0] d, output logic [31:0] q);
        @(posedge sys_clk_i);
        avs_address_i <= {i, 2'h0};
        avs_read_i <= !w;
        avs_write_i <= w;
        avs_writedata_i <= {24'h0, d};
        @(posedge sys_clk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge sys_clk_i);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus
    task wr(input logic [6:0] i, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, i, d, q);
    endtask : wr
    task rd_chk(input logic [6:0] i, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, i, 8'h00, q);
        chk(q, {24'h0, e});
    endtask : rd_chk
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] q;
        cyc_n(2);
        rst_n_i <= 1'b1;
        q = xs();
        lvl <= {2'b11, q[23:0]};
        cyc_n(8);
        for (int k = 0; k < 9; k++) rd_chk(tab_i[k], 8'h00);
        for (int k = 0; k < 9; k++)
        begin
            wr(tab_i[k], 8'hff);
            rd_chk(tab_i[k], tab_e[k]);
        end
        for (int k = 0; k < 9; k++) wr(tab_i[k], 8'h00);
        global_irq_enable_i <= 1'b1;
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < 4; c++)
            begin
                wr(7'h69, 8'(c << (2 * p)));
                wr(7'h1d, 8'(1 << p));
                wr(7'h1c, 8'h03);
                lvl[24 + p] <= 1'b0;
                cyc_n(8);
                chk(32'(irq_req_o), 32'(exp_pin(c, 1'b0)) << p);
                lvl[24 + p] <= 1'b1;
                cyc_n(8);
                chk(32'(irq_req_o), 32'(exp_pin(c, 1'b1)) << p);
                rd_chk(7'h1c, (c == 0) ? 8'h00 : 8'(1 << p));
                wr(7'h1c, 8'(1 << p));
                cyc_n(1);
                chk(32'(irq_req_o), 32'h0);
            end
        wr(7'h1d, 8'h00);
        for (int g = 0; g < 3; g++)
        begin
            q = xs();
            wr(7'(7'h6b + g), (q[7:0] & 8'hfd) | 8'h01);
            wr(7'h68, 8'(1 << g));
            lvl[8 * g + 1] <= ~lvl[8 * g + 1];
            cyc_n(8);
            chk(32'(irq_req_o), 32'h0);
            lvl[8 * g] <= ~lvl[8 * g];
            cyc_n(2);
            chk(32'(wake_o), 32'h1);
            cyc_n(6);
            chk(32'(irq_req_o), 32'(4 << g));
            global_irq_enable_i <= 1'b0;
            cyc_n(1);
            chk(32'(irq_req_o), 32'h0);
            global_irq_enable_i <= 1'b1;
            rd_chk(7'h1b, 8'(1 << g));
            irq_ack_i <= epi_req_s'(5'(4 << g));
            cyc_n(1);
            irq_ack_i <= '0;
            cyc_n(1);
            chk(32'(irq_req_o), 32'h0);
            wr(7'h68, 8'h00);
        end
        // group flag sets with its enable off, then clears by a written one
        lvl[0] <= ~lvl[0];
        cyc_n(8);
        rd_chk(7'h1b, 8'h01);
        wr(7'h1b, 8'h01);
        rd_chk(7'h1b, 8'h00);
        // pin a falling edge, cleared by the handler acknowledge
        wr(7'h69, 8'h02);
        wr(7'h1d, 8'h01);
        lvl[24] <= 1'b0;
        cyc_n(8);
        chk(32'(irq_req_o), 32'h1);
        irq_ack_i <= epi_req_s'(5'h01);
        cyc_n(1);
        irq_ack_i <= '0;
        cyc_n(1);
        chk(32'(irq_req_o), 32'h0);
        lvl[24] <= 1'b1;
        cyc_n(8);
        chk(32'(irq_req_o), 32'h0);
        close_out();
    end
endmodule : epi_top_tb_top

bind epi_top epi_top_assertions u_chk (.sys_clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .ext_irq_pin_a_i, .ext_irq_pin_b_i,
    .change_detect_inputs_i, .global_irq_enable_i, .irq_ack_i, .irq_req_o, .wake_o);
